// ### design/drsc_regs.svh
`ifndef DRSC_REGS_SVH
`define DRSC_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DRSC_CTRL        8'h00
`define DRSC_SEC_COUNT   8'h04
`define DRSC_SEC_ALARM   8'h08
`define DRSC_FLEX_COUNT  8'h0C
`define DRSC_FLEX_ALARM  8'h10
`define DRSC_FLEX_FINE   8'h14
`define DRSC_STATUS      8'h18
`define DRSC_MASK        8'h1C
`define DRSC_CAP_COUNT   8'h20
`define DRSC_CAP_FINE    8'h24
`define DRSC_STB_TGT     8'h30
`define DRSC_STB_CFG     8'h34
`define DRSC_STB_STRIDE  8'h08
`define DRSC_SMP_CFG     8'h50
`define DRSC_LAST_ADDR   8'h5C
// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define DRSC_ST_SEC_ALM  0
`define DRSC_ST_FLEX_ALM 1
`define DRSC_ST_PERIODIC 2
`define DRSC_ST_CAPTURE  3
`define DRSC_ST_SAMPLE   4
// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define DRSC_CTRL_RST    32'h0000_0000
`define DRSC_SEC_DIV     32768
`define DRSC_PER_UNITS   60
`define DRSC_RESP_OKAY   2'h0
`define DRSC_RESP_SLVERR 2'h2
`endif

// ### design/drsc_pkg.sv
package drsc_pkg;
    typedef struct packed {
        logic [15:0] rsv_hi;
        logic [3:0]  stb_en;
        logic        cap_en;
        logic        per_en;
        logic        flex_alm_en;
        logic        sec_alm_en;
        logic [3:0]  prescale;
        logic        rsv_lo;
        logic        clk_sel_xtal;
        logic        flex_en;
        logic        sec_en;
    } drsc_ctrl_t;

    typedef struct packed {
        logic [15:0] width;
        logic [15:0] period;
    } drsc_stb_cfg_t;

    typedef struct packed {
        logic [2:0] match;
        logic [2:0] mask;
    } drsc_smp_cfg_t;
endpackage

// ### design/drsc_top.sv
`timescale 1ns/1ps
`include "drsc_regs.svh"

// Summary of operation
// (RULE1) seconds counter divides crystal to 1 Hz
// (RULE2) flexible prescale by two to 0..15
// (RULE3) seconds on crystal, flexible on muxed source
// (RULE4) flexible alarm matches one source cycle
// (RULE5) seconds alarm fires once, absolute time
// (RULE6) flexible absolute alarm plus 60-unit periodic
// (RULE7) four strobe channels, programmable period, width
// (RULE8) strobe pulse starts at target count
// (RULE9) strobe runs independent of power mode
// (RULE10) capture input edge snapshots flexible count
// (RULE11) capture wakes, stores exact source cycle
// (RULE12) channel samples three inputs at pulse
// (RULE13) channel flags programmed input pattern
// (RULE14) seconds alarm has own wake interrupt
// (RULE15) seconds counter has no strobe, capture
// (RULE16) flags sticky, clearable, individually maskable
module drsc_top import drsc_pkg::*; #(
    parameter int CHANNELS = 4
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset,
    // axi4-lite slave
    input  wire logic [31:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [31:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // low frequency source ticks
    input  wire logic                  low_freq_crystal_tick,
    input  wire logic                  low_freq_internal_osc_tick,
    // sensor pins
    input  wire logic                  capture_in,
    input  wire logic [CHANNELS*3-1:0] sense_in,
    output logic [CHANNELS-1:0]        strobe_out,
    // wake requests
    output logic                       flex_irq,
    output logic                       sec_irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    drsc_ctrl_t    ctrl_r, ctrl_nxt;
    logic [31:0]   sec_alarm_r, sec_alarm_nxt, flex_alarm_r, flex_alarm_nxt;
    logic [14:0]   flex_fine_r, flex_fine_nxt;
    logic [7:0]    mask_r, mask_nxt, status_r, status_nxt;
    logic [31:0]   tgt_r [CHANNELS], tgt_nxt [CHANNELS];
    drsc_stb_cfg_t cfg_r [CHANNELS], cfg_nxt [CHANNELS];
    drsc_smp_cfg_t smp_r [CHANNELS], smp_nxt [CHANNELS];
    logic [14:0]   sec_pre_r, sec_pre_nxt, flex_pre_r, flex_pre_nxt;
    logic [31:0]   sec_cnt_r, sec_cnt_nxt, flex_cnt_r, flex_cnt_nxt;
    logic [5:0]    per_cnt_r, per_cnt_nxt;
    logic [31:0]   cap_cnt_r, cap_cnt_nxt;
    logic [14:0]   cap_fine_r, cap_fine_nxt;
    logic          cap_d_r;
    logic          run_r [CHANNELS], run_nxt [CHANNELS];
    logic [15:0]   phase_r [CHANNELS], phase_nxt [CHANNELS];
    logic [2:0]    last_r [CHANNELS], last_nxt [CHANNELS];
    logic [CHANNELS-1:0] out_r, out_nxt, smp_hit;
    logic          flex_irq_r, sec_irq_nxt, sec_irq_r, flex_irq_nxt;
    logic          lf_tick, unit_tick, sec_hit, flex_hit, per_hit, cap_edge;
    logic [14:0]   unit_mask;
    logic [7:0]    set_vec, clr_vec;
    // bus
    logic          aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, wr_en;
    logic [7:0]    awaddr_r, awaddr_nxt;
    logic [31:0]   wdata_r, wdata_nxt;
    logic [3:0]    wstrb_r, wstrb_nxt;
    logic          awready_r, awready_nxt, wready_r, wready_nxt;
    logic          bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic          rvalid_r, rvalid_nxt;
    logic [1:0]    bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]   rdata_r, rdata_nxt;
    logic [32:0]   wr_look, rd_look;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] wmerge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // bit 32 flags an unmapped address
    function automatic logic [32:0] rd_sel(input logic [7:0] a);
        logic [32:0] res;
        res = {1'b0, 32'h0000_0000};
        unique case (a)
            `DRSC_CTRL:       res[31:0] = ctrl_r;
            `DRSC_SEC_COUNT:  res[31:0] = sec_cnt_r;
            `DRSC_SEC_ALARM:  res[31:0] = sec_alarm_r;
            `DRSC_FLEX_COUNT: res[31:0] = flex_cnt_r;
            `DRSC_FLEX_ALARM: res[31:0] = flex_alarm_r;
            `DRSC_FLEX_FINE:  res[14:0] = flex_fine_r;
            `DRSC_STATUS:     res[7:0]  = status_r;
            `DRSC_MASK:       res[7:0]  = mask_r;
            `DRSC_CAP_COUNT:  res[31:0] = cap_cnt_r;
            `DRSC_CAP_FINE:   res[14:0] = cap_fine_r;
            default: begin
                res[32] = 1'b1;
                for (int c = 0; c < CHANNELS; c++) begin
                    if (a == `DRSC_STB_TGT + 8'(c) * `DRSC_STB_STRIDE) begin
                        res = {1'b0, tgt_r[c]};
                    end
                    if (a == `DRSC_STB_CFG + 8'(c) * `DRSC_STB_STRIDE) begin
                        res = {1'b0, cfg_r[c]};
                    end
                    if (a == `DRSC_SMP_CFG + 8'(c * 4)) begin
                        res = {1'b0, 21'h0, last_r[c], 1'b0,
                               smp_r[c].match, 1'b0, smp_r[c].mask};
                    end
                end
            end
        endcase
        return res;
    endfunction

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    assign wr_en = aw_hold_r & w_hold_r & ~bvalid_r;

    always_comb begin
        wr_look     = rd_sel(awaddr_r);
        rd_look     = rd_sel(s_axi_araddr[7:0]);
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (s_axi_awvalid && awready_r) begin
            aw_hold_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && wready_r) begin
            w_hold_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_en) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_look[32] ? `DRSC_RESP_SLVERR : `DRSC_RESP_OKAY;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd_look[31:0];
            rresp_nxt  = rd_look[32] ? `DRSC_RESP_SLVERR : `DRSC_RESP_OKAY;
        end
        awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
        wready_nxt  = ~w_hold_nxt & ~bvalid_nxt;
        arready_nxt = ~rvalid_nxt;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            {aw_hold_r, w_hold_r, bvalid_r, rvalid_r} <= 4'h0;
            {awready_r, wready_r, arready_r} <= 3'h0;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
            bresp_r  <= 2'h0;
            rresp_r  <= 2'h0;
            rdata_r  <= 32'h0000_0000;
        end else begin
            {aw_hold_r, w_hold_r} <= {aw_hold_nxt, w_hold_nxt};
            {bvalid_r, rvalid_r}  <= {bvalid_nxt, rvalid_nxt};
            {awready_r, wready_r, arready_r} <=
                {awready_nxt, wready_nxt, arready_nxt};
            awaddr_r <= awaddr_nxt;
            wdata_r  <= wdata_nxt;
            wstrb_r  <= wstrb_nxt;
            bresp_r  <= bresp_nxt;
            rresp_r  <= rresp_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // ------------------------------------------------------------
    // counters, alarms and capture
    // ------------------------------------------------------------
    assign lf_tick   = ctrl_r.clk_sel_xtal ? low_freq_crystal_tick :
                       low_freq_internal_osc_tick; // RULE3
    assign unit_mask = 15'((16'h0001 << ctrl_r.prescale) - 16'h0001);
    assign unit_tick = ctrl_r.flex_en & lf_tick &
                       ((flex_pre_r & unit_mask) == unit_mask); // RULE2
    assign sec_hit   = ctrl_r.sec_en & ctrl_r.sec_alm_en &
                       (sec_cnt_r == sec_alarm_r); // RULE5
    assign flex_hit  = ctrl_r.flex_en & ctrl_r.flex_alm_en & lf_tick &
                       (flex_cnt_r == flex_alarm_r) &
                       (flex_pre_r == flex_fine_r); // RULE4
    assign per_hit   = ctrl_r.per_en & unit_tick &
                       (per_cnt_r == 6'(`DRSC_PER_UNITS - 1)); // RULE6
    // seconds counter owns no capture path
    assign cap_edge  = ctrl_r.flex_en & ctrl_r.cap_en &
                       capture_in & ~cap_d_r; // RULE10 RULE15

    always_comb begin
        sec_pre_nxt  = sec_pre_r;
        sec_cnt_nxt  = sec_cnt_r;
        flex_pre_nxt = flex_pre_r;
        flex_cnt_nxt = flex_cnt_r;
        per_cnt_nxt  = per_cnt_r;
        cap_cnt_nxt  = cap_cnt_r;
        cap_fine_nxt = cap_fine_r;
        if (!ctrl_r.sec_en) begin
            sec_pre_nxt = 15'h0000;
            sec_cnt_nxt = 32'h0000_0000;
        end else if (low_freq_crystal_tick) begin
            if (sec_pre_r == 15'(`DRSC_SEC_DIV - 1)) begin // RULE1
                sec_pre_nxt = 15'h0000;
                sec_cnt_nxt = sec_cnt_r + 32'h0000_0001;
            end else begin
                sec_pre_nxt = sec_pre_r + 15'h0001;
            end
        end
        if (!ctrl_r.flex_en) begin
            flex_pre_nxt = 15'h0000;
            flex_cnt_nxt = 32'h0000_0000;
            per_cnt_nxt  = 6'h00;
        end else if (lf_tick) begin
            flex_pre_nxt = flex_pre_r + 15'h0001;
            if (unit_tick) begin
                flex_cnt_nxt = flex_cnt_r + 32'h0000_0001;
                per_cnt_nxt  = per_hit || per_cnt_r ==
                    6'(`DRSC_PER_UNITS - 1) ? 6'h00 : per_cnt_r + 6'h01;
            end
        end
        if (cap_edge) begin
            cap_cnt_nxt  = flex_cnt_r; // RULE11
            cap_fine_nxt = flex_pre_r;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            {sec_pre_r, flex_pre_r, cap_fine_r} <= {3{15'h0000}};
            {sec_cnt_r, flex_cnt_r, cap_cnt_r}  <= {3{32'h0000_0000}};
            per_cnt_r <= 6'h00;
            cap_d_r   <= 1'b0;
        end else begin
            {sec_pre_r, flex_pre_r, cap_fine_r} <=
                {sec_pre_nxt, flex_pre_nxt, cap_fine_nxt};
            {sec_cnt_r, flex_cnt_r, cap_cnt_r} <=
                {sec_cnt_nxt, flex_cnt_nxt, cap_cnt_nxt};
            per_cnt_r <= per_cnt_nxt;
            cap_d_r   <= capture_in;
        end
    end

    // ------------------------------------------------------------
    // strobe channels; no power mode input gates them
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            run_nxt[c]   = run_r[c];
            phase_nxt[c] = phase_r[c];
            last_nxt[c]  = last_r[c];
            smp_hit[c]   = 1'b0;
            if (!ctrl_r.stb_en[c] || !ctrl_r.flex_en) begin
                run_nxt[c]   = 1'b0;
                phase_nxt[c] = 16'h0000;
            end else if (!run_r[c]) begin
                run_nxt[c] = unit_tick && flex_cnt_r == tgt_r[c]; // RULE8
            end else if (lf_tick) begin
                // period 0 wraps at 65536 ticks, the 0.5 Hz end
                phase_nxt[c] = phase_r[c] == cfg_r[c].period - 16'h0001 ?
                               16'h0000 : phase_r[c] + 16'h0001; // RULE7
            end
            // sample at each rising edge of the pulse
            if (run_nxt[c] && phase_nxt[c] == 16'h0000 &&
                (!run_r[c] || lf_tick)) begin // RULE12 RULE9
                last_nxt[c] = sense_in[c*3 +: 3];
                smp_hit[c]  = smp_r[c].mask != 3'h0 &&
                    ((sense_in[c*3 +: 3] ^ smp_r[c].match) &
                     smp_r[c].mask) == 3'h0; // RULE13
            end
            out_nxt[c] = run_nxt[c] && phase_nxt[c] < cfg_r[c].width;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            out_r <= '0;
            for (int c = 0; c < CHANNELS; c++) begin
                run_r[c]   <= 1'b0;
                phase_r[c] <= 16'h0000;
                last_r[c]  <= 3'h0;
            end
        end else begin
            out_r   <= out_nxt;
            run_r   <= run_nxt;
            phase_r <= phase_nxt;
            last_r  <= last_nxt;
        end
    end

    assign strobe_out = out_r;

    // ------------------------------------------------------------
    // software registers and flags
    // ------------------------------------------------------------
    assign set_vec = {4'(smp_hit), cap_edge, per_hit, flex_hit, sec_hit};
    assign clr_vec = wr_en && awaddr_r == `DRSC_STATUS ?
                     wdata_r[7:0] & {8{wstrb_r[0]}} : 8'h00;

    always_comb begin
        ctrl_nxt       = ctrl_r;
        sec_alarm_nxt  = sec_alarm_r;
        flex_alarm_nxt = flex_alarm_r;
        flex_fine_nxt  = flex_fine_r;
        mask_nxt       = mask_r;
        tgt_nxt        = tgt_r;
        cfg_nxt        = cfg_r;
        smp_nxt        = smp_r;
        if (wr_en) begin
            unique case (awaddr_r)
                `DRSC_CTRL:       ctrl_nxt = wmerge(ctrl_r, wdata_r, wstrb_r);
                `DRSC_SEC_ALARM:  sec_alarm_nxt =
                    wmerge(sec_alarm_r, wdata_r, wstrb_r);
                `DRSC_FLEX_ALARM: flex_alarm_nxt =
                    wmerge(flex_alarm_r, wdata_r, wstrb_r);
                `DRSC_FLEX_FINE:  flex_fine_nxt =
                    15'(wmerge({17'h0, flex_fine_r}, wdata_r, wstrb_r));
                `DRSC_MASK:       mask_nxt =
                    wstrb_r[0] ? wdata_r[7:0] : mask_r;
                default: begin
                    for (int c = 0; c < CHANNELS; c++) begin
                        if (awaddr_r == `DRSC_STB_TGT +
                            8'(c) * `DRSC_STB_STRIDE) begin
                            tgt_nxt[c] = wmerge(tgt_r[c], wdata_r, wstrb_r);
                        end
                        if (awaddr_r == `DRSC_STB_CFG +
                            8'(c) * `DRSC_STB_STRIDE) begin
                            cfg_nxt[c] = wmerge(cfg_r[c], wdata_r, wstrb_r);
                        end
                        if (awaddr_r == `DRSC_SMP_CFG + 8'(c * 4) &&
                            wstrb_r[0]) begin
                            smp_nxt[c] = {wdata_r[6:4], wdata_r[2:0]};
                        end
                    end
                end
            endcase
        end
        ctrl_nxt.rsv_hi = 16'h0000;
        ctrl_nxt.rsv_lo = 1'b0;
        // one-shot alarms disarm themselves; a hit beats a rewrite
        if (sec_hit) ctrl_nxt.sec_alm_en = 1'b0; // RULE5
        if (flex_hit) ctrl_nxt.flex_alm_en = 1'b0;
        status_nxt   = (status_r & ~clr_vec) | set_vec; // RULE16
        sec_irq_nxt  = status_nxt[`DRSC_ST_SEC_ALM] &
                       mask_nxt[`DRSC_ST_SEC_ALM]; // RULE14
        flex_irq_nxt = |(status_nxt[7:1] & mask_nxt[7:1]); // RULE11 RULE16
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_r       <= `DRSC_CTRL_RST;
            sec_alarm_r  <= 32'h0000_0000;
            flex_alarm_r <= 32'h0000_0000;
            flex_fine_r  <= 15'h0000;
            {mask_r, status_r} <= 16'h0000;
            {sec_irq_r, flex_irq_r} <= 2'h0;
            for (int c = 0; c < CHANNELS; c++) begin
                tgt_r[c] <= 32'h0000_0000;
                cfg_r[c] <= 32'h0000_0000;
                smp_r[c] <= 6'h00;
            end
        end else begin
            ctrl_r       <= ctrl_nxt;
            sec_alarm_r  <= sec_alarm_nxt;
            flex_alarm_r <= flex_alarm_nxt;
            flex_fine_r  <= flex_fine_nxt;
            {mask_r, status_r} <= {mask_nxt, status_nxt};
            {sec_irq_r, flex_irq_r} <= {sec_irq_nxt, flex_irq_nxt};
            tgt_r <= tgt_nxt;
            cfg_r <= cfg_nxt;
            smp_r <= smp_nxt;
        end
    end

    assign sec_irq  = sec_irq_r;
    assign flex_irq = flex_irq_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sec_tick_a: assert property (@(posedge clock) disable iff (reset) // RULE1
        ctrl_r.sec_en && low_freq_crystal_tick && sec_pre_r == 15'h7FFF
        |=> sec_cnt_r == $past(sec_cnt_r) + 32'h1 && sec_pre_r == 15'h0)
        else $error("seconds did not advance at prescale wrap");
    flex_unit_a: assert property (@(posedge clock) disable iff (reset) // RULE2
        lf_tick && ctrl_r.flex_en && (flex_pre_r & unit_mask) != unit_mask
        |=> flex_cnt_r == $past(flex_cnt_r))
        else $error("flexible count moved off a unit boundary");
    clk_mux_a: assert property (@(posedge clock) disable iff (reset) // RULE3
        ctrl_r.flex_en && !ctrl_r.clk_sel_xtal &&
        !low_freq_internal_osc_tick |=> flex_pre_r == $past(flex_pre_r))
        else $error("flexible prescaler ran on unselected source");
    fine_alarm_a: assert property (@(posedge clock) disable iff (reset) // RULE4
        flex_hit |=> status_r[`DRSC_ST_FLEX_ALM] && !ctrl_r.flex_alm_en)
        else $error("fine alarm hit not flagged");
    sec_once_a: assert property (@(posedge clock) disable iff (reset) // RULE5
        sec_hit && !(wr_en && awaddr_r == `DRSC_CTRL)
        |=> !ctrl_r.sec_alm_en ##1 !sec_hit)
        else $error("seconds alarm fired twice");
    periodic_a: assert property (@(posedge clock) disable iff (reset) // RULE6
        per_hit |-> per_cnt_r == 6'd59 ##1 per_cnt_r == 6'd0)
        else $error("periodic alarm off its 60-unit step");
    strobe_go_a: assert property (@(posedge clock) disable iff (reset) // RULE8
        !run_r[0] && run_nxt[0] && cfg_r[0].width != 16'h0
        |=> strobe_out[0] && run_r[0])
        else $error("strobe pulse missing at target");
    capture_a: assert property (@(posedge clock) disable iff (reset) // RULE10
        cap_edge |=> cap_cnt_r == $past(flex_cnt_r) &&
        cap_fine_r == $past(flex_pre_r) && status_r[`DRSC_ST_CAPTURE])
        else $error("capture snapshot wrong");
    irq_mask_a: assert property (@(posedge clock) disable iff (reset) // RULE16
        $rose(flex_irq) |-> |(status_r[7:1] & mask_r[7:1]))
        else $error("interrupt raised with no unmasked flag");
endmodule // drsc_top

// ### tb/drsc_sensor_model.sv
`timescale 1ns/1ps
module drsc_sensor_model (
    // pins
    input  wire logic        clock,
    input  wire logic        fire,
    input  wire logic [3:0]  strobe_out,
    output logic             capture_in,
    output logic [11:0]      sense_in
);
    // state reported only after the first measurement request
    always @(posedge clock)
        sense_in <= strobe_out[0] || sense_in === 12'h005 ? 12'h005 : 12'h000;
    always @(posedge clock) capture_in <= fire;
endmodule // drsc_sensor_model

// ### tb/dual_rtc_strobe_capture_bench.sv
`timescale 1ns/1ps
`include "drsc_regs.svh"
module dual_rtc_strobe_capture_bench;
    import drsc_pkg::*;
    logic clock, reset, fire, low_freq_crystal_tick;
    logic low_freq_internal_osc_tick, capture_in, flex_irq, sec_irq;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb, strobe_out;
    logic [11:0] sense_in;
    int k = 0, i, mismatches = 0, comparisons = 0;
    drsc_top DUT (.*);
    drsc_sensor_model sensor (.clock, .fire, .strobe_out, .capture_in,
                              .sense_in);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ------------------------------------------------------------
    // source ticks, unrelated rates
    // ------------------------------------------------------------
    always @(posedge clock) begin
        k <= k + 1;
        low_freq_crystal_tick <= (k % 4 == 3);
        low_freq_internal_osc_tick <= (k % 3 == 2);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        check(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er,
                      input logic [31:0] ed);
        s_axi_araddr <= {24'h0, a};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        check(s_axi_rresp, er);
        check(s_axi_rdata, ed);
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        {reset, fire} = 2'h2;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        rd(`DRSC_CTRL, 2'h0, 32'h0);
        rd(8'h60, 2'h2, 32'h0);
        wr(8'h28, 32'h1, 2'h2);
        wr(`DRSC_STB_TGT, 32'h8, 2'h0);
        wr(`DRSC_STB_CFG, 32'h0002_0010, 2'h0);
        wr(`DRSC_SMP_CFG, 32'h57, 2'h0);
        wr(`DRSC_MASK, 32'h08, 2'h0);
        wr(`DRSC_CTRL, 32'h1806, 2'h0);
        for (i = 0; i < 400 && strobe_out[0] !== 1'b1; i++) @(posedge clock);
        check(strobe_out[0], 1'b1);
        repeat (160) @(posedge clock);
        rd(`DRSC_STATUS, 2'h0, 32'h10);
        rd(`DRSC_SMP_CFG, 2'h0, 32'h557);
        check(flex_irq, 1'b0);
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        repeat (4) @(posedge clock);
        check(flex_irq, 1'b1);
        wr(`DRSC_STATUS, 32'h08, 2'h0);
        check(flex_irq, 1'b0);
        wr(`DRSC_MASK, 32'h09, 2'h0);
        wr(`DRSC_CTRL, 32'h1907, 2'h0);
        repeat (4) @(posedge clock);
        check(sec_irq, 1'b1);
        rd(`DRSC_CTRL, 2'h0, 32'h1807);
        wr(`DRSC_CTRL, 32'h0, 2'h0);
        wr(`DRSC_FLEX_ALARM, 32'h2, 2'h0);
        wr(`DRSC_FLEX_FINE, 32'h5, 2'h0);
        wr(`DRSC_MASK, 32'h06, 2'h0);
        wr(`DRSC_CTRL, 32'h0612, 2'h0);
        repeat (450) @(posedge clock);
        check(flex_irq, 1'b1);
        check(sec_irq, 1'b0);
        rd(`DRSC_STATUS, 2'h0, 32'h17);
        rd(`DRSC_CTRL, 2'h0, 32'h0412);
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        tally_and_finish();
    end
endmodule // dual_rtc_strobe_capture_bench
